// >>> design/sparb_rr_pick.sv
`include "sparb_defines.svh"

module sparb_rr_pick
   import sparb_pkg::*;
#(
   parameter int CHANNELS = `SPARB_CHANNELS
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [CHANNELS-1:0] req,
   input wire logic load,
   input wire logic [`SPARB_IDX_W-1:0] loadIdx,
   output logic pickValid,
   output logic [`SPARB_IDX_W-1:0] pickIdx
);

   logic [`SPARB_IDX_W-1:0] lastQ;
   logic [`SPARB_IDX_W-1:0] lastD;
   logic pickValidQ;
   logic pickValidD;
   logic [`SPARB_IDX_W-1:0] pickIdxQ;
   logic [`SPARB_IDX_W-1:0] pickIdxD;

   // =====================================================================
   // Rotation search
   // Search starts just past the last owner, so nobody holds fixed priority
   function automatic logic [`SPARB_IDX_W:0] rrSearch(
      input logic [CHANNELS-1:0] r,
      input logic [`SPARB_IDX_W-1:0] last
   );
      logic [`SPARB_IDX_W:0] res;
      int c;
      res = '0;
      for (int k = CHANNELS; k >= 1; k--)
      begin
         c = (int'(last) + k) % CHANNELS;
         if (r[c])
         begin
            res = {1'b1, c[`SPARB_IDX_W-1:0]};
         end
      end
      return res;
   endfunction

   always_comb
   begin
      lastD = lastQ;
      if (load)
      begin
         lastD = loadIdx;
      end
      {pickValidD, pickIdxD} = rrSearch(req, lastD);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lastQ <= `SPARB_LAST_RESET;
         pickValidQ <= 1'b0;
         pickIdxQ <= '0;
      end
      else
      begin
         lastQ <= lastD;
         pickValidQ <= pickValidD;
         pickIdxQ <= pickIdxD;
      end
   end

   assign pickValid = pickValidQ;
   assign pickIdx = pickIdxQ;

endmodule

// >>> design/sparb_top.sv
// Notes on behaviour
// - External arbiter rotates over four slots and bridge, no fixed priority.
// - External arbiter only guaranteed up to 33 MHz; faster needs built-in.
// - Select low: built-in arbiter serves slots, indicator LED off.
// - Select high: external arbiter serves slots, indicator LED lit; above 33 MHz built-in serves, LED off.
// - Each slot request and grant goes to exactly one arbiter.
// - Built-in disabled: bridge grant-zero pin carries the bridge's own request.
// - Built-in disabled: bridge request-zero pin carries grant to the bridge.
// - Pairs 0 to 3 serve slots J4, J3, J2, J1; built-in serves all four.
// - Arbiter and slot timing come from one clock synchronous to primary.
// - Switch OFF reads as 1, ON reads as 0.
`include "sparb_defines.svh"

module sparb_top
   import sparb_pkg::*;
#(
   parameter int SLOTS = `SPARB_SLOTS,
   parameter int CHANNELS = `SPARB_CHANNELS,
   parameter int BUS_CLK_HZ = `SPARB_CLK_HZ
)
(
   // Secondary bus clock, derived from the primary clock
   input wire logic clk,
   input wire logic rstn,
   input wire logic arbiterChoice,
   input wire logic [SLOTS-1:0] slotReqN,
   output logic [SLOTS-1:0] slotGntN,
   input wire logic bridgeGrantZeroPinN,
   input wire logic [SLOTS-1:1] bridgeGntN,
   output logic bridgeRequestZeroPinN,
   output logic [SLOTS-1:1] bridgeReqN,
   input wire logic frameN,
   input wire logic irdyN,
   output logic arbiterIndicatorLed
);

   // =====================================================================
   // Mode selection
   // Above the external arbiter's rate limit the switch is overridden
   localparam logic EXT_ALLOWED = (BUS_CLK_HZ <= `SPARB_EXT_MAX_HZ);

   logic extModeQ;
   logic extModeD;
   logic modeChange;
   sparb_state_t stateQ;
   sparb_state_t stateD;

   always_comb
   begin
      extModeD = extModeQ;
      // Mode only flips while the external arbiter holds no grant,
      // so an owner granted by the external arbiter never loses its grant mid-transfer
      if (stateQ == SPARB_ST_IDLE)
      begin
         extModeD = (arbiterChoice == `SPARB_CHOICE_EXTERNAL) && EXT_ALLOWED;
      end
   end

   assign modeChange = extModeD != extModeQ;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         extModeQ <= 1'b0;
      end
      else
      begin
         extModeQ <= extModeD;
      end
   end

   // =====================================================================
   // External arbiter requests
   // Channels 0..3 are slots J4, J3, J2, J1; channel 4 is the bridge
   logic [CHANNELS-1:0] extReq;
   logic busIdle;
   logic pickValid;
   logic [`SPARB_IDX_W-1:0] pickIdx;
   logic pickLoad;
   logic [`SPARB_IDX_W-1:0] ownerQ;
   logic [`SPARB_IDX_W-1:0] ownerD;
   logic [CHANNELS-1:0] extGntQ;
   logic [CHANNELS-1:0] extGntD;

   always_comb
   begin
      extReq = '0;
      if (extModeQ)
      begin
         extReq[SLOTS-1:0] = ~slotReqN;
         extReq[`SPARB_BRIDGE_CH] = ~bridgeGrantZeroPinN;
      end
   end

   assign busIdle = frameN && irdyN;

   sparb_rr_pick #(
      .CHANNELS(CHANNELS)
   ) uRrPick (
      .clk(clk),
      .rstn(rstn),
      .req(extReq),
      .load(pickLoad),
      .loadIdx(ownerD),
      .pickValid(pickValid),
      .pickIdx(pickIdx)
   );

   // =====================================================================
   // Grant sequencing
   always_comb
   begin
      stateD = stateQ;
      ownerD = ownerQ;
      pickLoad = 1'b0;
      extGntD = '0;
      case (stateQ)
         SPARB_ST_IDLE:
         begin
            // Pick is one cycle old, so recheck the request is still up
            if (extModeQ && !modeChange && pickValid && extReq[pickIdx] && busIdle)
            begin
               stateD = SPARB_ST_GRANT;
               ownerD = pickIdx;
               pickLoad = 1'b1;
               extGntD[pickIdx] = 1'b1;
            end
         end
         SPARB_ST_GRANT:
         begin
            if (extReq[ownerQ])
            begin
               extGntD[ownerQ] = 1'b1;
            end
            else
            begin
               stateD = SPARB_ST_RELEASE;
            end
         end
         SPARB_ST_RELEASE:
         begin
            // Owner may still be finishing its transfer; wait for idle bus
            if (busIdle)
            begin
               stateD = SPARB_ST_IDLE;
            end
         end
         default:
         begin
            stateD = SPARB_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stateQ <= SPARB_ST_IDLE;
         ownerQ <= `SPARB_LAST_RESET;
         extGntQ <= '0;
      end
      else
      begin
         stateQ <= stateD;
         ownerQ <= ownerD;
         extGntQ <= extGntD;
      end
   end

   // =====================================================================
   // Request and grant routing
   // Every pin is registered, which costs one cycle of path delay
   logic [SLOTS-1:0] slotGntND;
   logic [SLOTS-1:0] slotGntNQ;
   logic bridgeReq0ND;
   logic bridgeReq0NQ;
   logic [SLOTS-1:1] bridgeReqND;
   logic [SLOTS-1:1] bridgeReqNQ;
   logic ledD;
   logic ledQ;

   always_comb
   begin
      if (extModeQ)
      begin
         slotGntND = ~extGntQ[SLOTS-1:0];
         bridgeReq0ND = ~extGntQ[`SPARB_BRIDGE_CH];
         bridgeReqND = {(SLOTS-1){`SPARB_PIN_IDLE}};
         ledD = `SPARB_LED_ON;
      end
      else
      begin
         slotGntND = {bridgeGntN, bridgeGrantZeroPinN};
         bridgeReq0ND = slotReqN[0];
         bridgeReqND = slotReqN[SLOTS-1:1];
         ledD = `SPARB_LED_OFF;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         slotGntNQ <= {SLOTS{`SPARB_PIN_IDLE}};
         bridgeReq0NQ <= `SPARB_PIN_IDLE;
         bridgeReqNQ <= {(SLOTS-1){`SPARB_PIN_IDLE}};
         ledQ <= `SPARB_LED_OFF;
      end
      else
      begin
         slotGntNQ <= slotGntND;
         bridgeReq0NQ <= bridgeReq0ND;
         bridgeReqNQ <= bridgeReqND;
         ledQ <= ledD;
      end
   end

   // Single clock domain throughout; no crossings needed
   assign slotGntN = slotGntNQ;
   assign bridgeRequestZeroPinN = bridgeReq0NQ;
   assign bridgeReqN = bridgeReqNQ;
   assign arbiterIndicatorLed = ledQ;

endmodule

// >>> include/sparb_defines.svh
`ifndef SPARB_DEFINES_SVH
`define SPARB_DEFINES_SVH

// =====================================================================
// Channel layout
`define SPARB_SLOTS 4
`define SPARB_CHANNELS 5
`define SPARB_BRIDGE_CH 3'h4
`define SPARB_IDX_W 3

// =====================================================================
// Select switch levels
`define SPARB_CHOICE_INTERNAL 1'b0
`define SPARB_CHOICE_EXTERNAL 1'b1

// =====================================================================
// Clock limits and reset values
`define SPARB_CLK_HZ 20000000
`define SPARB_EXT_MAX_HZ 33000000
`define SPARB_PIN_IDLE 1'b1
`define SPARB_LED_OFF 1'b0
`define SPARB_LED_ON 1'b1
`define SPARB_LAST_RESET 3'h4

`endif

// >>> include/sparb_pkg.sv
package sparb_pkg;

   // =====================================================================
   // External arbiter sequencing
   typedef enum logic [2:0]
   {
      SPARB_ST_IDLE = 3'b001,
      SPARB_ST_GRANT = 3'b010,
      SPARB_ST_RELEASE = 3'b100
   } sparb_state_t;

endpackage

// >>> verification/sparb_bridge_model.sv
module sparb_bridge_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic extMode,
   input wire logic bridgeWantN,
   input wire logic [3:0] reqN,
   output logic [3:0] gntN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] grant_q;
   // ====
   // Built-in arbiter, lowest channel wins
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         grant_q <= 4'hf;
      else
         grant_q <= ~(~reqN & -(~reqN));
   // Disabled: pin 0 is own request
   assign gntN = extMode ? {3'h7, bridgeWantN} : grant_q;
endmodule

// >>> verification/sparb_top_checker.sv
module sparb_top_checker
#(
   parameter int SLOTS = 4,
   parameter int BUS_CLK_HZ = 20000000
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic arbiterChoice,
   input wire logic [SLOTS-1:0] slotReqN,
   input wire logic [SLOTS-1:0] slotGntN,
   input wire logic bridgeGrantZeroPinN,
   input wire logic [SLOTS-1:1] bridgeGntN,
   input wire logic bridgeRequestZeroPinN,
   input wire logic [SLOTS-1:1] bridgeReqN,
   input wire logic arbiterIndicatorLed
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire led = arbiterIndicatorLed;
   property p_one; led |-> $onehot0(~{bridgeRequestZeroPinN, slotGntN}); endproperty
   a_one: assert property (p_one) else $error("two grants");
   property p_on; $rose(led) |-> $past(arbiterChoice, 2); endproperty
   a_on: assert property (p_on) else $error("led on");
   property p_off; $fell(led) |-> !$past(arbiterChoice, 2); endproperty
   a_off: assert property (p_off) else $error("led off");
   property p_gnt; !led && $past(rstn) |-> slotGntN == $past({bridgeGntN, bridgeGrantZeroPinN});
   endproperty
   a_gnt: assert property (p_gnt) else $error("grant route");
   property p_req; !led && $past(rstn) |-> {bridgeReqN, bridgeRequestZeroPinN} == $past(slotReqN);
   endproperty
   a_req: assert property (p_req) else $error("req route");
   property p_ext; led |-> &bridgeReqN; endproperty
   a_ext: assert property (p_ext) else $error("req leak");
   property p_own; $fell(bridgeRequestZeroPinN) && led |-> $past(!bridgeGrantZeroPinN); endproperty
   a_own: assert property (p_own) else $error("bridge grant");
   property p_clk; BUS_CLK_HZ > 33000000 |-> !led; endproperty
   a_clk: assert property (p_clk) else $error("too fast");
endmodule

bind sparb_top sparb_top_checker #(.SLOTS(SLOTS), .BUS_CLK_HZ(BUS_CLK_HZ)) sparb_top_checker_inst
   (.clk, .rstn, .arbiterChoice, .slotReqN, .slotGntN, .bridgeGrantZeroPinN, .bridgeGntN,
   .bridgeRequestZeroPinN, .bridgeReqN, .arbiterIndicatorLed);

// >>> verification/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, choice = 0, busN = 1, wantN = 1;
   logic [3:0] reqN = 4'hf;
   wire [3:0] sGntN, bGnt, bReq;
   wire led;
   wire fastLed;
   wire [4:0] gnt = {bReq[0], sGntN};
   int mismatches = 0, checks_done = 0;
   initial forever #25 clk = ~clk;
   sparb_top sparb_top_inst (.clk(clk), .rstn(rstn), .arbiterChoice(choice), .slotReqN(reqN),
      .slotGntN(sGntN), .bridgeGrantZeroPinN(bGnt[0]), .bridgeGntN(bGnt[3:1]),
      .bridgeRequestZeroPinN(bReq[0]), .bridgeReqN(bReq[3:1]), .frameN(busN), .irdyN(busN),
      .arbiterIndicatorLed(led));
   sparb_bridge_model sparb_bridge_model_inst (.clk(clk), .rstn(rstn), .extMode(led),
      .bridgeWantN(wantN), .reqN(bReq), .gntN(bGnt));
   // Fast bus copy: the switch must never reach the external arbiter
   if (1)
   begin : g_fast
      sparb_top #(.BUS_CLK_HZ(66000000)) sparb_top_inst (.clk(clk), .rstn(rstn),
         .arbiterChoice(choice), .slotReqN(reqN), .slotGntN(), .bridgeGrantZeroPinN(bGnt[0]),
         .bridgeGntN(bGnt[3:1]), .bridgeRequestZeroPinN(), .bridgeReqN(), .frameN(busN),
         .irdyN(busN), .arbiterIndicatorLed(fastLed));
   end
   // ====
   // Shared tasks
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task results();
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // ====
   // Scenarios
   task t_builtin();
      choice = 0;
      cyc(3);
      chk({7'h0, led}, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         reqN = ~(4'h1 << i);
         cyc(3);
         chk({bReq, sGntN}, {2{~(4'h1 << i)}});
      end
      reqN = 4'hf;
      cyc(3);
   endtask
   task t_ext();
      choice = 1;
      cyc(3);
      chk({3'h0, led, bReq}, 8'h1f);
      chk({7'h0, fastLed}, 8'h00);
   endtask
   // Every channel asks at once; bus held busy after each owner leaves.
   // Slot owners ask again at once, so a fixed priority would win the bus back
   task t_rr();
      int w;
      reqN = 4'h0;
      wantN = 0;
      for (int k = 0; k < 5; k++)
      begin
         w = 0;
         while (gnt === 5'h1f && w < 20)
         begin
            cyc(1);
            w++;
         end
         if (gnt === 5'h1f)
         begin
            mismatches++;
            results();
         end
         chk({3'h0, gnt}, {3'h0, ~(5'h1 << k)});
         busN = 0;
         {wantN, reqN} = {wantN, reqN} | (5'h1 << k);
         cyc(4);
         chk({3'h0, gnt}, 8'h1f);
         busN = 1;
         if (k < 4)
         begin
            reqN[k] = 1'b0;
         end
      end
      reqN = 4'hf;
   endtask
   initial
   begin
      cyc(6);
      rstn = 1;
      cyc(1);
      t_builtin();
      t_ext();
      t_rr();
      t_builtin();
      results();
   end
endmodule
